// File: twm_params.svh
// Constants for the two-wire master byte engine
//
// Behaviour
// - START waits until the bus is seen free, then goes out.
// - After START the event flag rises with status 0x08.
// - Address direction bit picks transmit mode or receive mode.
// - After read address and acknowledge, status is 0x38, 0x40 or 0x48.
// - Clear with stop=1, start=0 sends STOP and clears stop request.
// - Clear with stop=1, start=1 sends STOP then START, clears stop.
// - Clear with start=1, stop=0 sends repeated START, status 0x10.
// - After repeated START the bus stays owned, no STOP needed.
// - Acknowledged data byte reports 0x28; all follow-ups allowed.
// - Not-acknowledged data byte reports 0x30; same follow-ups allowed.
// - Lost arbitration reports 0x38 and releases the bus at once; clear with start=0 returns to idle.
// - Clear after lost arbitration with start=1 retries START when free.
// - Plain clear shifts the loaded address or transmit byte out, then samples acknowledge; in receive mode it shifts a byte in.
// - Status prescaler bits always read as zero.
// - Bus transfer stays suspended while the event flag is set.
// - Data write while flag low is dropped and sets write collision.
`ifndef TWM_PARAMS_SVH
`define TWM_PARAMS_SVH

`define TWM_ADDR_W          2
`define TWM_OFS_CONTROL     2'h0
`define TWM_OFS_STATUS      2'h1
`define TWM_OFS_DATA        2'h2

`define TWM_CTRL_RESET      8'h00
`define TWM_DATA_RESET      8'hff
`define TWM_STATUS_MASK     8'hf8

`define TWM_ST_START        8'h08
`define TWM_ST_RSTART       8'h10
`define TWM_ST_AW_ACK       8'h18
`define TWM_ST_AW_NACK      8'h20
`define TWM_ST_TX_ACK       8'h28
`define TWM_ST_TX_NACK      8'h30
`define TWM_ST_ARB_LOST     8'h38
`define TWM_ST_AR_ACK       8'h40
`define TWM_ST_AR_NACK      8'h48
`define TWM_ST_RX_ACK       8'h50
`define TWM_ST_RX_NACK      8'h58
`define TWM_ST_NO_INFO      8'hf8

`define TWM_CLK_PERIOD_NS   10
`define TWM_HALF_BIT_NS     5000
`define TWM_HALF_BIT_CYC    ((`TWM_HALF_BIT_NS + `TWM_CLK_PERIOD_NS - 1) / `TWM_CLK_PERIOD_NS)
`define TWM_TIMER_W         10

`endif

// File: twm_pkg.sv
// Types shared by the two-wire master byte engine
package twm_pkg;

    typedef struct packed {
        logic event_flag;
        logic ack_enable;
        logic start_request;
        logic stop_request;
        logic write_collision;
        logic interface_enable;
        logic reserved;
        logic irq_enable;
    } twm_ctrl_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } twm_pins_t;

    typedef enum logic [3:0] {
        TWM_IDLE, TWM_WAIT_FREE, TWM_START_A, TWM_START_B, TWM_HOLD,
        TWM_BIT_LOW, TWM_BIT_HIGH, TWM_ACK_LOW, TWM_ACK_HIGH,
        TWM_STOP_A, TWM_STOP_B, TWM_STOP_C, TWM_RSTART_A, TWM_RSTART_B
    } twm_state_t;

endpackage : twm_pkg

// File: twm_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module twm_pin_sync (
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic pin_i,
    output logic      level_o
);
    logic stage1_reg;
    logic stage2_reg;
    logic stage3_reg;

    // Idle bus is high, so all stages reset high
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            stage1_reg <= 1'b1;
            stage2_reg <= 1'b1;
            stage3_reg <= 1'b1;
        end else begin
            stage1_reg <= pin_i;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // A change counts only once the last two stages agree
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            level_o <= 1'b1;
        end else if (stage2_reg == stage3_reg) begin
            level_o <= stage3_reg;
        end
    end
endmodule : twm_pin_sync

// File: twm_phase_timer.sv
// Half-bit phase timer for the bus waveform
`include "twm_params.svh"
`timescale 1ns/1ps
module twm_phase_timer (
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic restart_i,
    output logic      done_o
);
    localparam logic [`TWM_TIMER_W-1:0] LAST = `TWM_TIMER_W'(`TWM_HALF_BIT_CYC - 1);

    logic [`TWM_TIMER_W-1:0] count_reg;

    always_ff @(posedge clk_i) begin
        if (reset_i || restart_i) begin
            count_reg <= '0;
        end else if (count_reg != LAST) begin
            count_reg <= count_reg + `TWM_TIMER_W'(1);
        end
    end

    assign done_o = (count_reg == LAST) && !restart_i;
endmodule : twm_phase_timer

// File: twm_byte_engine.sv
// Two-wire bus master byte engine with control, status and data registers
//
// The implementer's own choices: strobed register access and the register offsets.
`include "twm_params.svh"
`timescale 1ns/1ps
module twm_byte_engine
    import twm_pkg::*;
(
    input  wire logic                   clk_i,
    input  wire logic                   reset_i,
    input  wire logic [`TWM_ADDR_W-1:0] addr_i,
    input  wire logic [7:0]             wdata_i,
    input  wire logic                   write_i,
    input  wire logic                   read_i,
    output logic      [7:0]             rdata_o,
    input  wire twm_pkg::twm_pins_t     pins_i,
    output twm_pkg::twm_pins_t          pins_o,
    output twm_pkg::twm_pins_t          pins_oe_o,
    output logic                        irq_o
);
    import twm_pkg::*;

    twm_ctrl_t  ctrl_reg;
    logic [7:0] data_reg;
    logic [7:0] status_reg;
    logic [7:0] shift_reg;
    logic [2:0] bit_cnt_reg;
    twm_state_t state_reg;
    twm_state_t prev_state_reg;
    logic       scl_low_reg;
    logic       sda_low_reg;
    logic       owned_reg;
    logic       addr_phase_reg;
    logic       rx_mode_reg;
    logic       rx_byte_reg;
    logic       lost_reg;
    logic       flag_set_reg;
    logic       stop_done_reg;
    logic       rx_load_reg;
    logic       busy_reg;
    logic       sda_prev_reg;
    logic       scl_prev_reg;
    logic       scl_s;
    logic       sda_s;
    logic       timer_done;
    logic       timer_restart;
    logic       ctrl_write;
    logic       data_write;
    logic       resume;
    logic       waits_high;

    twm_pin_sync u_scl_sync (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .pin_i   (pins_i.scl),
        .level_o (scl_s)
    );

    twm_pin_sync u_sda_sync (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .pin_i   (pins_i.sda),
        .level_o (sda_s)
    );

    // Phases with SCL released count only once SCL is seen high, so slaves may stretch
    assign waits_high    = (state_reg == TWM_BIT_HIGH) || (state_reg == TWM_ACK_HIGH) ||
                           (state_reg == TWM_STOP_B) || (state_reg == TWM_RSTART_B);
    assign timer_restart = (state_reg != prev_state_reg) || (waits_high && !scl_s);

    twm_phase_timer u_timer (
        .clk_i     (clk_i),
        .reset_i   (reset_i),
        .restart_i (timer_restart),
        .done_o    (timer_done)
    );

    assign ctrl_write = write_i && (addr_i == `TWM_OFS_CONTROL);
    assign data_write = write_i && (addr_i == `TWM_OFS_DATA);
    // Writing the flag bit as one while it is set hands the bus back to the engine
    assign resume     = ctrl_write && wdata_i[7] && ctrl_reg.event_flag;

    // Open-drain pins: only ever pull low
    assign pins_o.scl    = 1'b0;
    assign pins_o.sda    = 1'b0;
    assign pins_oe_o.scl = scl_low_reg;
    assign pins_oe_o.sda = sda_low_reg;

    assign irq_o = ctrl_reg.event_flag && ctrl_reg.irq_enable;

    // Control register
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ctrl_reg <= `TWM_CTRL_RESET;
        end else begin
            if (ctrl_write) begin
                ctrl_reg.ack_enable       <= wdata_i[6];
                ctrl_reg.start_request    <= wdata_i[5];
                ctrl_reg.stop_request     <= wdata_i[4];
                ctrl_reg.interface_enable <= wdata_i[2];
                ctrl_reg.irq_enable       <= wdata_i[0];
                if (wdata_i[7]) begin
                    ctrl_reg.event_flag <= 1'b0;
                end
            end
            if (stop_done_reg) begin
                ctrl_reg.stop_request <= 1'b0;
            end
            // A new event in the clearing cycle is kept
            if (flag_set_reg) begin
                ctrl_reg.event_flag <= 1'b1;
            end
            if (data_write) begin
                ctrl_reg.write_collision <= !ctrl_reg.event_flag;
            end
            if (!ctrl_reg.interface_enable) begin
                ctrl_reg.event_flag <= flag_set_reg;
            end
        end
    end

    // Data register: software loads only while the flag is high, received bytes land here
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            data_reg <= `TWM_DATA_RESET;
        end else if (rx_load_reg) begin
            data_reg <= shift_reg;
        end else if (data_write && ctrl_reg.event_flag) begin
            data_reg <= wdata_i;
        end
    end

    // Read port, answer one cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_o <= 8'h00;
        end else if (read_i) begin
            unique case (addr_i)
                `TWM_OFS_CONTROL: rdata_o <= ctrl_reg;
                `TWM_OFS_STATUS:  rdata_o <= status_reg & `TWM_STATUS_MASK;
                `TWM_OFS_DATA:    rdata_o <= data_reg;
                default:          rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

    // Bus busy tracking from START and STOP seen on the wire
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            busy_reg     <= 1'b0;
            sda_prev_reg <= 1'b1;
            scl_prev_reg <= 1'b1;
        end else begin
            sda_prev_reg <= sda_s;
            scl_prev_reg <= scl_s;
            if (scl_s && scl_prev_reg && sda_prev_reg && !sda_s) begin
                busy_reg <= 1'b1;
            end else if (scl_s && scl_prev_reg && !sda_prev_reg && sda_s) begin
                busy_reg <= 1'b0;
            end
        end
    end

    // Sequencer: waveform, byte shifting and status events
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_reg      <= TWM_IDLE;
            prev_state_reg <= TWM_IDLE;
            scl_low_reg    <= 1'b0;
            sda_low_reg    <= 1'b0;
            owned_reg      <= 1'b0;
            addr_phase_reg <= 1'b0;
            rx_mode_reg    <= 1'b0;
            rx_byte_reg    <= 1'b0;
            lost_reg       <= 1'b0;
            flag_set_reg   <= 1'b0;
            stop_done_reg  <= 1'b0;
            rx_load_reg    <= 1'b0;
            shift_reg      <= 8'h00;
            bit_cnt_reg    <= 3'h0;
            status_reg     <= `TWM_ST_NO_INFO;
        end else begin
            prev_state_reg <= state_reg;
            flag_set_reg   <= 1'b0;
            stop_done_reg  <= 1'b0;
            rx_load_reg    <= 1'b0;
            if (!ctrl_reg.interface_enable) begin
                state_reg   <= TWM_IDLE;
                scl_low_reg <= 1'b0;
                sda_low_reg <= 1'b0;
                owned_reg   <= 1'b0;
                lost_reg    <= 1'b0;
            end else begin
                unique case (state_reg)
                    TWM_IDLE: begin
                        if (ctrl_reg.start_request && !ctrl_reg.event_flag && !flag_set_reg) begin
                            state_reg <= TWM_WAIT_FREE;
                        end
                    end
                    TWM_WAIT_FREE: begin
                        if (!busy_reg && scl_s && sda_s) begin
                            sda_low_reg <= 1'b1;
                            state_reg   <= TWM_START_A;
                        end
                    end
                    TWM_START_A: begin
                        if (timer_done) begin
                            scl_low_reg <= 1'b1;
                            state_reg   <= TWM_START_B;
                        end
                    end
                    TWM_START_B: begin
                        if (timer_done) begin
                            status_reg     <= owned_reg ? `TWM_ST_RSTART : `TWM_ST_START;
                            owned_reg      <= 1'b1;
                            addr_phase_reg <= 1'b1;
                            flag_set_reg   <= 1'b1;
                            state_reg      <= TWM_HOLD;
                        end
                    end
                    TWM_HOLD: begin
                        if (resume) begin
                            if (lost_reg) begin
                                // Bus already released; idle watches the bus as a plain listener
                                lost_reg  <= 1'b0;
                                state_reg <= TWM_IDLE;
                            end else if (wdata_i[4]) begin
                                sda_low_reg <= 1'b1;
                                state_reg   <= TWM_STOP_A;
                            end else if (wdata_i[5]) begin
                                sda_low_reg <= 1'b0;
                                state_reg   <= TWM_RSTART_A;
                            end else begin
                                rx_byte_reg <= rx_mode_reg && !addr_phase_reg;
                                shift_reg   <= data_reg;
                                bit_cnt_reg <= 3'h7;
                                state_reg   <= TWM_BIT_LOW;
                            end
                        end
                    end
                    TWM_BIT_LOW: begin
                        sda_low_reg <= !rx_byte_reg && !shift_reg[7];
                        if (timer_done) begin
                            scl_low_reg <= 1'b0;
                            state_reg   <= TWM_BIT_HIGH;
                        end
                    end
                    TWM_BIT_HIGH: begin
                        if (timer_done) begin
                            scl_low_reg <= 1'b1;
                            shift_reg   <= {shift_reg[6:0], sda_s};
                            if (!rx_byte_reg && !sda_low_reg && !sda_s) begin
                                // Another master drove low while we sent a one
                                sda_low_reg    <= 1'b0;
                                scl_low_reg    <= 1'b0;
                                owned_reg      <= 1'b0;
                                lost_reg       <= 1'b1;
                                addr_phase_reg <= 1'b0;
                                status_reg     <= `TWM_ST_ARB_LOST;
                                flag_set_reg   <= 1'b1;
                                state_reg      <= TWM_HOLD;
                            end else if (bit_cnt_reg == 3'h0) begin
                                state_reg <= TWM_ACK_LOW;
                            end else begin
                                bit_cnt_reg <= bit_cnt_reg - 3'h1;
                                state_reg   <= TWM_BIT_LOW;
                            end
                        end
                    end
                    TWM_ACK_LOW: begin
                        // Receiver answers per ack enable; software clears it for the last byte
                        sda_low_reg <= rx_byte_reg && ctrl_reg.ack_enable;
                        if (timer_done) begin
                            scl_low_reg <= 1'b0;
                            state_reg   <= TWM_ACK_HIGH;
                        end
                    end
                    TWM_ACK_HIGH: begin
                        if (timer_done) begin
                            scl_low_reg  <= 1'b1;
                            sda_low_reg  <= 1'b0;
                            flag_set_reg <= 1'b1;
                            state_reg    <= TWM_HOLD;
                            if (addr_phase_reg) begin
                                addr_phase_reg <= 1'b0;
                                rx_mode_reg    <= shift_reg[0];
                                if (shift_reg[0]) begin
                                    status_reg <= sda_s ? `TWM_ST_AR_NACK : `TWM_ST_AR_ACK;
                                end else begin
                                    status_reg <= sda_s ? `TWM_ST_AW_NACK : `TWM_ST_AW_ACK;
                                end
                            end else if (rx_byte_reg) begin
                                rx_load_reg <= 1'b1;
                                status_reg  <= sda_low_reg ? `TWM_ST_RX_ACK : `TWM_ST_RX_NACK;
                            end else begin
                                status_reg <= sda_s ? `TWM_ST_TX_NACK : `TWM_ST_TX_ACK;
                            end
                        end
                    end
                    TWM_STOP_A: begin
                        if (timer_done) begin
                            scl_low_reg <= 1'b0;
                            state_reg   <= TWM_STOP_B;
                        end
                    end
                    TWM_STOP_B: begin
                        if (timer_done) begin
                            sda_low_reg <= 1'b0;
                            state_reg   <= TWM_STOP_C;
                        end
                    end
                    TWM_STOP_C: begin
                        if (timer_done) begin
                            owned_reg     <= 1'b0;
                            stop_done_reg <= 1'b1;
                            status_reg    <= `TWM_ST_NO_INFO;
                            state_reg     <= TWM_IDLE;
                        end
                    end
                    TWM_RSTART_A: begin
                        if (timer_done) begin
                            scl_low_reg <= 1'b0;
                            state_reg   <= TWM_RSTART_B;
                        end
                    end
                    TWM_RSTART_B: begin
                        if (timer_done) begin
                            sda_low_reg <= 1'b1;
                            state_reg   <= TWM_START_A;
                        end
                    end
                endcase
            end
        end
    end
endmodule : twm_byte_engine

// File: twm_byte_checker.sv
// Port assertions for the two-wire master byte engine
`include "twm_params.svh"
`timescale 1ns/1ps
module twm_byte_checker
    import twm_pkg::*;
(
    input wire logic                   clk_i,
    input wire logic                   reset_i,
    input wire logic [`TWM_ADDR_W-1:0] addr_i,
    input wire logic [7:0]             wdata_i,
    input wire logic                   write_i,
    input wire logic                   read_i,
    input wire logic [7:0]             rdata_o,
    input wire twm_pkg::twm_pins_t     pins_i,
    input wire twm_pkg::twm_pins_t     pins_o,
    input wire twm_pkg::twm_pins_t     pins_oe_o,
    input wire logic                   irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    a_rdata_idle: assert property (!read_i |=> rdata_o == 8'h00) else $error("rdata not zero"); // [RESET]
    a_open_drain: assert property (pins_o == 2'h0) else $error("pin driven high"); // [RESET]
    a_status_mask: assert property (read_i && addr_i == 2'h1 |=> rdata_o[2:0] == 3'h0)
        else $error("status low bits set");
    a_ctrl_reserved: assert property (read_i && addr_i == 2'h0 |=> !rdata_o[1]) else $error("reserved bit set");
    a_unmapped_zero: assert property (read_i && addr_i == 2'h3 |=> rdata_o == 8'h00) else $error("unmapped read");
    a_flag_holds: assert property (irq_o && !(write_i && addr_i == 2'h0) |=> irq_o)
        else $error("flag dropped");
    a_bus_frozen: assert property (irq_o && !write_i |=> $stable(pins_oe_o)) else $error("bus moved");
    a_start_timing: assert property ($rose(pins_oe_o.sda) && !pins_oe_o.scl |-> ##[498:502] $rose(pins_oe_o.scl))
        else $error("start timing");
    a_stop_quiet: assert property ($fell(pins_oe_o.sda) && !pins_oe_o.scl |=> !irq_o [*8])
        else $error("flag after stop");
    a_reset_idle: assert property ($fell(reset_i) |-> pins_oe_o == 2'h0 && !irq_o) else $error("reset state"); // [RESET]
    c_flag_set: cover property ($rose(irq_o));
    c_stop: cover property ($fell(pins_oe_o.sda) && !pins_oe_o.scl);
    c_start: cover property ($rose(pins_oe_o.sda) && !pins_oe_o.scl);
endmodule : twm_byte_checker

bind twm_byte_engine twm_byte_checker u_chk (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o), .pins_i(pins_i),
    .pins_o(pins_o), .pins_oe_o(pins_oe_o), .irq_o(irq_o));

// File: twm_slave_model.sv
// Behavioural slave device on the two-wire bus
`timescale 1ns/1ps
module twm_slave_model (
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    input  wire logic       ack_i,
    input  wire logic [7:0] tx_i,
    output logic            sda_pull_o,
    output logic [7:0]      rx_o
);
    logic [7:0] sh = 8'h00;
    logic [7:0] tx_sh = 8'h00;
    logic       active = 0;
    logic       in_addr = 0;
    logic       reading = 0;
    logic       mack = 0;
    int         cnt = 0;
    initial sda_pull_o = 0;
    initial rx_o = 8'h00;
    // A START also covers a repeated START, so the bit count restarts
    always @(negedge sda_i) if (scl_i) begin
        active = 1; in_addr = 1; reading = 0; cnt = 0; sda_pull_o = 0;
    end
    always @(posedge sda_i) if (scl_i) active = 0;
    always @(posedge scl_i) if (active) begin
        if (cnt < 8) sh = {sh[6:0], sda_i};
        else if (cnt == 8) mack = ~sda_i;
        cnt++;
    end
    always @(negedge scl_i) if (active) begin
        if (cnt == 8) begin
            if (!reading || in_addr) begin
                rx_o = sh;
                if (in_addr) reading = sh[0];
                sda_pull_o = ack_i;
            end else sda_pull_o = 0;
        end else if (cnt == 9) begin
            cnt = 0;
            // Stop sending once the master refuses a byte
            if (reading && (in_addr || mack)) begin
                sda_pull_o = ~tx_i[7];
                tx_sh = tx_i << 1;
            end else sda_pull_o = 0;
            in_addr = 0;
        end else if (cnt > 0 && reading && !in_addr) begin
            sda_pull_o = ~tx_sh[7];
            tx_sh = tx_sh << 1;
        end
    end
endmodule : twm_slave_model

// File: tb.sv
// Self-checking bench for the two-wire master byte engine
`include "twm_params.svh"
`timescale 1ns/1ps
module tb;
    import twm_pkg::*;
    logic       clk_i = 0;
    logic       reset_i = 1;
    logic [1:0] addr_i = 2'h0;
    logic [7:0] wdata_i = 8'h00;
    logic       write_i = 0;
    logic       read_i = 0;
    logic [7:0] rdata_o;
    twm_pins_t  pins_i, pins_o, pins_oe_o;
    logic       irq_o, sda_pull, ack_sel = 1, sda_grab = 0;
    logic [7:0] rx_byte, tx_sel = 8'h00, d, b, b1, saddr;
    int         error_cnt = 0;
    int         checks_done = 0;
    int         i;
    // Open-drain wires with pull-ups
    // A second bus owner is stood in for by sda_grab, to force lost arbitration
    assign pins_i = {~pins_oe_o.scl, ~(pins_oe_o.sda | sda_pull | sda_grab)};
    initial forever #5 clk_i = ~clk_i;
    twm_byte_engine u_dut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o), .pins_i(pins_i), .pins_o(pins_o),
        .pins_oe_o(pins_oe_o), .irq_o(irq_o));
    twm_slave_model u_slave (.scl_i(pins_i.scl), .sda_i(pins_i.sda), .ack_i(ack_sel), .tx_i(tx_sel),
        .sda_pull_o(sda_pull), .rx_o(rx_byte));
    task tally_and_finish;
        if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk_i); addr_i <= a; wdata_i <= v; write_i <= 1;
        @(posedge clk_i); write_i <= 0;
    endtask : wr
    task rd(input logic [1:0] a, output logic [7:0] v);
        @(posedge clk_i); addr_i <= a; read_i <= 1;
        @(posedge clk_i); read_i <= 0;
        #1 v = rdata_o;
    endtask : rd
    // Write control, wait for the event flag, compare the status code
    task step(input logic [7:0] ctl, input logic [7:0] st, input string n);
        int k;
        wr(2'h0, ctl);
        // Let the clearing edge settle, else the old flag ends the wait at once
        #1;
        for (k = 0; k < 20000 && irq_o !== 1'b1; k++) begin
            @(posedge clk_i);
            #1;
        end
        if (irq_o !== 1'b1) begin
            chk("irq_o", 8'h01, {7'h0, irq_o});
            tally_and_finish();
        end
        rd(2'h1, d);
        chk(n, st, d);
    endtask : step
    initial begin
        saddr = 8'($urandom(32'h8b706220)) & 8'hfe;
        repeat (10) @(posedge clk_i);
        reset_i <= 0;
        rd(2'h0, d); chk("ctrl", `TWM_CTRL_RESET, d); // [RESET]
        rd(2'h1, d); chk("status", `TWM_ST_NO_INFO, d); // [RESET]
        rd(2'h2, d); chk("data", `TWM_DATA_RESET, d); // [RESET]
        rd(2'h3, d); chk("unmapped", 8'h00, d); // [RESET]
        wr(2'h2, 8'h5a); rd(2'h0, d); chk("collision", 8'h08, d);
        rd(2'h2, d); chk("data kept", `TWM_DATA_RESET, d);
        step(8'ha5, `TWM_ST_START, "start");
        chk("irq on", 8'h01, {7'h0, irq_o});
        wr(2'h0, 8'h04); #1 chk("irq off", 8'h00, {7'h0, irq_o});
        wr(2'h0, 8'h05); wr(2'h2, saddr); rd(2'h0, d); chk("collision clr", 8'h85, d);
        step(8'h85, `TWM_ST_AW_ACK, "addr write");
        for (int k = 0; k < 3; k++) begin
            b = 8'($urandom);
            ack_sel = (k == 2) ? 1'($urandom) : (k == 0);
            wr(2'h2, b);
            step(8'h85, ack_sel ? `TWM_ST_TX_ACK : `TWM_ST_TX_NACK, "tx status");
            chk("slave rx", b, rx_byte);
        end
        ack_sel = 1;
        step(8'ha5, `TWM_ST_RSTART, "rstart");
        b1 = 8'($urandom); tx_sel = b1;
        wr(2'h2, saddr | 8'h01); step(8'h85, `TWM_ST_AR_ACK, "addr read");
        tx_sel = 8'($urandom);
        step(8'hc5, `TWM_ST_RX_ACK, "rx ack"); rd(2'h2, d); chk("rx byte", b1, d);
        step(8'h85, `TWM_ST_RX_NACK, "rx nack"); rd(2'h2, d); chk("last byte", tx_sel, d);
        step(8'hb5, `TWM_ST_START, "stop start"); rd(2'h0, d); chk("stop bit", 8'ha5, d);
        wr(2'h2, saddr); step(8'h85, `TWM_ST_AW_ACK, "addr write 2");
        sda_grab = 1;
        wr(2'h2, 8'hff); step(8'h85, `TWM_ST_ARB_LOST, "arb lost");
        chk("arb release", 8'h00, {6'h0, pins_oe_o});
        sda_grab = 0;
        step(8'ha5, `TWM_ST_START, "arb retry");
        wr(2'h0, 8'h95);
        for (i = 0; i < 3000; i++) begin
            rd(2'h0, d);
            if (d[4] === 1'b0) break;
        end
        chk("after stop", 8'h05, d);
        rd(2'h1, d); chk("status idle", `TWM_ST_NO_INFO, d);
        chk("released", 8'h00, {6'h0, pins_oe_o});
        tally_and_finish();
    end
endmodule : tb
